// *** src/tmg_pkg.sv ***
/*
  Package for the time mark generator: relay hold periods and sampler depth.
  Assumes a 25 MHz system clock; all light gates and the reference wave are
  asynchronous pins.
*/
package tmg_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 25000000;
  localparam int SEC_HOLD_MS   = 100;
  localparam int MIN_HOLD_MS   = 500;
  localparam int HOUR_HOLD_MS  = 1000;
  localparam int SEC_HOLD_CYC  = SEC_HOLD_MS * (CLK_HZ / 1000);
  localparam int MIN_HOLD_CYC  = MIN_HOLD_MS * (CLK_HZ / 1000);
  localparam int HOUR_HOLD_CYC = HOUR_HOLD_MS * (CLK_HZ / 1000);
  localparam int CNT_W         = 25;
  localparam int SYNC_DEPTH    = 3;

  // ---------------------------------------------------------------
  // Stretcher states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TMG_IDLE = 2'b01,
    TMG_HOLD = 2'b10
  } tmg_state_e;

endpackage

// *** src/tmg_stretch.sv ***
/*
  One pulse stretcher: a rising trigger closes the relay for HOLD_CYC cycles.
  Assumes trig is already synchronous to clk; retriggers while held are ignored.
*/
`timescale 1ns/1ps
module tmg_stretch #(
  parameter int HOLD_CYC = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trig,
  output logic      closed
);
  import tmg_pkg::*;

  tmg_state_e         state_reg, state_next;
  logic [CNT_W-1:0]   cnt_reg, cnt_next;
  logic               trig_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      TMG_IDLE: begin
        if (trig && !trig_reg) begin
          state_next = TMG_HOLD;
          cnt_next   = CNT_W'(HOLD_CYC - 1);
        end
      end
      TMG_HOLD: begin
        if (cnt_reg == '0) begin
          state_next = TMG_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: state_next = TMG_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= TMG_IDLE;
      cnt_reg   <= '0;
      trig_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      trig_reg  <= trig;
    end
  end

  assign closed = (state_reg == TMG_HOLD);

  // Helper count of consecutive closed cycles. A hold of millions of cycles
  // cannot be written as a delay, so its length is counted instead.
  logic [CNT_W-1:0]   seen_reg, seen_next;

  always_comb begin
    seen_next = closed ? (seen_reg + 1'b1) : '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seen_reg <= '0;
    end else begin
      seen_reg <= seen_next;
    end
  end

  chk_hold_length: assert property (@(posedge clk) disable iff (rst)
    $fell(closed) |-> (seen_reg == CNT_W'(HOLD_CYC)))
    else $error("relay hold length wrong");

  chk_no_level_fire: assert property (@(posedge clk) disable iff (rst)
    (state_reg == TMG_IDLE && !(trig && !trig_reg)) |=> !closed)
    else $error("relay closed without rising trigger");

endmodule

// *** src/tmg_top.sv ***
/*
  Time mark generator: second, minute and hour relay marks from light gates
  gated against a 50 c/s reference, with six-hourly omission.
  Assumes all gate and reference inputs are asynchronous pins, active high.
*/
// Notes on behaviour
// - Second trigger needs gate and reference rise.
// - First reference rise in gate triggers; dark ignored.
// - Stretchers fire on rising trigger only.
// - Minute fires on second pulse inside minute gate.
// - Hour fires on minute pulse inside hour gate.
// - Every mark starts at a second boundary.
// - Each closure lasts its own fixed period.
// - NAND of hour, six-hour gates inhibits minute.
// - Inhibit omits both minute and hour marks.
// - Second pulse goes to comparison selector.
// - Expose second NO/NC, minute and hour NO.
// - Gates pulse per second, minute, hour, six hours.
`timescale 1ns/1ps
module tmg_top (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ref_wave,
  input  wire logic gate_sec,
  input  wire logic gate_min,
  input  wire logic gate_hour,
  input  wire logic gate_six,
  output logic      sec_make,
  output logic      normally_closed_contact,
  output logic      min_make,
  output logic      hour_make,
  output logic      cmp_pulse
);
  import tmg_pkg::*;

  // ---------------------------------------------------------------
  // Input sampling
  // ---------------------------------------------------------------
  // Light gates and the reference drift against clk, so each passes three
  // stages and only counts when the last two agree.
  localparam int NIN = 5;
  logic [NIN-1:0] pin_in;
  logic [NIN-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
  logic [NIN-1:0] s1_next, s2_next, s3_next, clean_next;

  assign pin_in = {gate_six, gate_hour, gate_min, gate_sec, ref_wave};

  always_comb begin
    s1_next    = pin_in;
    s2_next    = s1_reg;
    s3_next    = s2_reg;
    // A bit moves only when the last two stages agree, so a pin caught
    // mid-change never shows up as a short glitch on the clean level.
    clean_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (clean_reg & (s2_reg ^ s3_reg));
  end

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_agree
      always_ff @(posedge clk) begin
        if (rst) begin
          clean_reg[gi] <= 1'b0;
        end else begin
          clean_reg[gi] <= clean_next[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  logic ref_c, gsec_c, gmin_c, ghour_c, gsix_c;
  assign {gsix_c, ghour_c, gmin_c, gsec_c, ref_c} = clean_reg;

  // ---------------------------------------------------------------
  // Coincidence gates
  // ---------------------------------------------------------------
  logic ref_prev_reg, ref_prev_next;
  logic sec_trig, min_trig, hour_trig, inhibit_n;
  logic sec_closed, min_closed, hour_closed;
  logic sec_prev_reg, min_prev_reg, sec_rise, min_rise;

  always_comb ref_prev_next = ref_c;

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_prev_next;
    end
  end

  // Gating the reference rise, not the light edge, is what aligns marks.
  assign sec_trig  = gsec_c && ref_c && !ref_prev_reg;
  // Only the first cycle of a closure may gate the next stage, so a light gate
  // that opens partway through a mark cannot start a late, misaligned one.
  assign sec_rise  = sec_closed && !sec_prev_reg;
  assign min_rise  = min_closed && !min_prev_reg;
  assign inhibit_n = !(ghour_c && gsix_c);
  assign min_trig  = sec_rise && gmin_c && inhibit_n;
  assign hour_trig = min_rise && ghour_c;

  // ---------------------------------------------------------------
  // Stretchers and relay contacts
  // ---------------------------------------------------------------
  tmg_stretch #(.HOLD_CYC(SEC_HOLD_CYC)) u_sec (
    .clk    (clk),
    .rst    (rst),
    .trig   (sec_trig),
    .closed (sec_closed)
  );

  tmg_stretch #(.HOLD_CYC(MIN_HOLD_CYC)) u_min (
    .clk    (clk),
    .rst    (rst),
    .trig   (min_trig),
    .closed (min_closed)
  );

  tmg_stretch #(.HOLD_CYC(HOUR_HOLD_CYC)) u_hour (
    .clk    (clk),
    .rst    (rst),
    .trig   (hour_trig),
    .closed (hour_closed)
  );

  logic sec_make_reg, min_make_reg, hour_make_reg, cmp_reg;
  logic sec_make_next, min_make_next, hour_make_next, cmp_next;
  logic sec_prev_next, min_prev_next;

  always_comb begin
    sec_make_next  = sec_closed;
    min_make_next  = min_closed;
    hour_make_next = hour_closed;
    sec_prev_next  = sec_closed;
    min_prev_next  = min_closed;
    cmp_next       = sec_rise;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sec_make_reg  <= 1'b0;
      min_make_reg  <= 1'b0;
      hour_make_reg <= 1'b0;
      sec_prev_reg  <= 1'b0;
      min_prev_reg  <= 1'b0;
      cmp_reg       <= 1'b0;
    end else begin
      sec_make_reg  <= sec_make_next;
      min_make_reg  <= min_make_next;
      hour_make_reg <= hour_make_next;
      sec_prev_reg  <= sec_prev_next;
      min_prev_reg  <= min_prev_next;
      cmp_reg       <= cmp_next;
    end
  end

  assign sec_make                = sec_make_reg;
  assign normally_closed_contact = !sec_make_reg;
  assign min_make                = min_make_reg;
  assign hour_make               = hour_make_reg;
  assign cmp_pulse               = cmp_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_sec_fire;
    sec_trig ##1 sec_closed;
  endsequence

  chk_sec_coincide: assert property (@(posedge clk) disable iff (rst)
    $rose(sec_closed) |-> $past(gsec_c && ref_c && !ref_prev_reg))
    else $error("second mark without gate and reference rise");

  chk_dark_ignored: assert property (@(posedge clk) disable iff (rst)
    (!gsec_c && !sec_closed) |=> !sec_closed)
    else $error("second mark fired while gate dark");

  chk_min_window: assert property (@(posedge clk) disable iff (rst)
    $rose(min_closed) |-> $past(sec_closed && gmin_c && inhibit_n))
    else $error("minute mark outside window");

  chk_hour_window: assert property (@(posedge clk) disable iff (rst)
    $rose(hour_closed) |-> $past(min_closed && ghour_c))
    else $error("hour mark outside window");

  chk_six_inhibit: assert property (@(posedge clk) disable iff (rst)
    (ghour_c && gsix_c && !min_closed) |=> !min_closed)
    else $error("minute mark during six-hour inhibit");

  chk_contact_pair: assert property (@(posedge clk) disable iff (rst)
    s_sec_fire |=> sec_make && !normally_closed_contact)
    else $error("second contacts wrong after fire");

  chk_cmp_pulse: assert property (@(posedge clk) disable iff (rst)
    $rose(sec_closed) |=> cmp_pulse ##1 !cmp_pulse)
    else $error("comparison pulse missing");

  // A later mark may only start one cycle after the faster one has started.
  chk_aligned_min: assert property (@(posedge clk) disable iff (rst)
    $rose(min_closed) |-> ($past(sec_closed) && !$past(sec_closed, 2)))
    else $error("minute mark not aligned to second");

  chk_aligned_hour: assert property (@(posedge clk) disable iff (rst)
    $rose(hour_closed) |-> ($past(min_closed) && !$past(min_closed, 2)))
    else $error("hour mark not aligned to minute");

  // Reset itself is watched here, so this check carries no disable.
  chk_reset_idle: assert property (@(posedge clk)
    rst |=> (!sec_make && !min_make && !hour_make && !cmp_pulse && normally_closed_contact))
    else $error("relay not open after reset");

endmodule

// *** verif/tmg_recorder.sv ***
/*
  Recorder model: counts relay closures and comparator pulses at the far side.
  Assumes every contact output is a level synchronous to clk.
*/
`timescale 1ns/1ps
module tmg_recorder (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sec_make,
  input  wire logic       nc_contact,
  input  wire logic       min_make,
  input  wire logic       hour_make,
  input  wire logic       cmp_pulse,
  output logic      [7:0] sec_cnt,
  output logic      [7:0] min_cnt,
  output logic      [7:0] cmp_cnt,
  output logic      [7:0] hour_cnt,
  output logic            nc_bad
);
  logic [2:0] last_reg;

  // Counting edges, not levels, shows a retrigger that should have been ignored.
  always @(posedge clk) begin
    if (rst) begin
      last_reg <= 3'h0;
      hour_cnt <= 8'h00;
      sec_cnt  <= 8'h00;
      min_cnt  <= 8'h00;
      cmp_cnt  <= 8'h00;
      nc_bad   <= 1'b0;
    end else begin
      last_reg <= {hour_make, min_make, sec_make};
      if (hour_make && !last_reg[2]) hour_cnt <= hour_cnt + 8'h01;
      if (sec_make && !last_reg[0]) sec_cnt <= sec_cnt + 8'h01;
      if (min_make && !last_reg[1]) min_cnt <= min_cnt + 8'h01;
      if (cmp_pulse === 1'b1) cmp_cnt <= cmp_cnt + 8'h01;
      if (nc_contact !== ~sec_make) nc_bad <= 1'b1;
    end
  end
endmodule

// *** verif/tmg_top_tb_top.sv ***
/*
  Testbench for the time mark generator, one task per scenario.
  Assumes relay holds far longer than the run, so each scenario resets first.
*/
`timescale 1ns/1ps
module tmg_top_tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ref_wave = 1'b0;
  logic       gate_sec = 1'b0;
  logic       gate_min = 1'b0;
  logic       gate_hour = 1'b0;
  logic       gate_six = 1'b0;
  logic       sec_make, nc_c, min_make, hour_make, cmp_pulse, nc_bad;
  logic [7:0] sec_cnt, min_cnt, cmp_cnt, hour_cnt;
  int         bad_count = 0;
  int         checks_done = 0;
  int         cycles = 0;

  always #20 clk = ~clk;

  tmg_top dut_u (.clk(clk), .rst(rst), .ref_wave(ref_wave), .gate_sec(gate_sec),
    .gate_min(gate_min), .gate_hour(gate_hour), .gate_six(gate_six), .sec_make(sec_make),
    .normally_closed_contact(nc_c), .min_make(min_make), .hour_make(hour_make),
    .cmp_pulse(cmp_pulse));

  tmg_recorder rec_u (.clk(clk), .rst(rst), .sec_make(sec_make), .nc_contact(nc_c),
    .min_make(min_make), .hour_make(hour_make), .cmp_pulse(cmp_pulse), .sec_cnt(sec_cnt),
    .min_cnt(min_cnt), .cmp_cnt(cmp_cnt), .hour_cnt(hour_cnt), .nc_bad(nc_bad));

  task automatic check1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    {rst, ref_wave, gate_sec, gate_min, gate_hour, gate_six} = 6'h20;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask

  // Raises the reference and waits, bounded, for the second relay to close.
  task automatic fire_sec(output int n);
    n = 0;
    ref_wave = 1'b1;
    while (sec_make !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic t_reset();
    do_reset();
    check1(sec_make, 1'b0);
    check1(nc_c, 1'b1);
    check1(min_make | hour_make | cmp_pulse, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_alone();
    do_reset();
    gate_sec = 1'b1;
    repeat (12) @(negedge clk);
    check1(sec_make, 1'b0);
    gate_sec = 1'b0;
    ref_wave = 1'b1;
    repeat (12) @(negedge clk);
    check1(sec_make, 1'b0);
    $display("test single input done");
  endtask

  task automatic t_second();
    int n;
    do_reset();
    gate_sec = 1'b1;
    repeat (3) @(negedge clk);
    fire_sec(n);
    check1(sec_make, 1'b1);
    check1(n >= 4 && n <= 9, 1'b1);
    check1(cmp_pulse, 1'b1);
    check1(nc_c, 1'b0);
    @(negedge clk);
    check1(cmp_pulse, 1'b0);
    ref_wave = 1'b0;
    repeat (4) @(negedge clk);
    ref_wave = 1'b1;
    repeat (12) @(negedge clk);
    check1(sec_make, 1'b1);
    check8(cmp_cnt, 8'h01);
    check8(sec_cnt, 8'h01);
    check1(min_make, 1'b0);
    check1(nc_bad, 1'b0);
    $display("test second mark done");
  endtask

  task automatic t_minute(input logic hr, input logic six, input logic em, input logic eh);
    int n;
    do_reset();
    {gate_sec, gate_min, gate_hour, gate_six} = {2'h3, hr, six};
    repeat (3) @(negedge clk);
    fire_sec(n);
    @(negedge clk);
    check1(min_make, em);
    repeat (3) @(negedge clk);
    check1(hour_make, eh);
    check8(min_cnt, {7'h00, em});
    check8(hour_cnt, {7'h00, eh});
    $display("test minute and hour done");
  endtask

  // The minute gate opens only after the second mark has begun.
  task automatic t_late_gate();
    int n;
    do_reset();
    gate_sec = 1'b1;
    repeat (3) @(negedge clk);
    fire_sec(n);
    gate_min = 1'b1;
    repeat (12) @(negedge clk);
    check1(sec_make, 1'b1);
    check1(min_make, 1'b0);
    check8(min_cnt, 8'h00);
    $display("test late minute gate done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // The scenarios need under two hundred cycles; this ceiling means a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    t_reset();
    t_alone();
    t_second();
    t_minute(1'b1, 1'b0, 1'b1, 1'b1);
    t_minute(1'b0, 1'b1, 1'b1, 1'b0);
    t_minute(1'b1, 1'b1, 1'b0, 1'b0);
    t_late_gate();
    final_report();
  end
endmodule
